//--- design/rlfs_consts.vh
// constants for the radio link forward/status block
// assumes inclusion by rlfs_top.v and by the testbench
`ifndef RLFS_CONSTS_VH
`define RLFS_CONSTS_VH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define RLFS_IDX_LINES 7'h00
`define RLFS_IDX_SENT 7'h01
`define RLFS_IDX_GOOD 7'h02
`define RLFS_IDX_UNSENT 7'h03
`define RLFS_IDX_BAD 7'h07
`define RLFS_IDX_NOBUF 7'h08
`define RLFS_IDX_DUP 7'h09
`define RLFS_IDX_LOST 7'h0c
`define RLFS_IDX_MAP_FIRST 7'h43
`define RLFS_IDX_MAP_LAST 7'h52
`define RLFS_IDX_CTRL 7'h60
`define RLFS_IDX_IRQ_STAT 7'h61
`define RLFS_IDX_IRQ_MASK 7'h62

// ****************************************
// line status bit positions
// ****************************************
`define RLFS_LINE_CTS 0
`define RLFS_LINE_RTS 1
`define RLFS_LINE_DSR 2
`define RLFS_LINE_DCD 3
`define RLFS_LINE_DTR 4

// ****************************************
// control register fields
// ****************************************
`define RLFS_CTRL_STATION_LSB 0
`define RLFS_CTRL_SF_EN 8
`define RLFS_CTRL_DTR 9
`define RLFS_CTRL_RTS 10
`define RLFS_CTRL_CLEAR 16
`define RLFS_CTRL_RESET 11'h000

// ****************************************
// event / counter indices
// ****************************************
`define RLFS_EV_SENT 0
`define RLFS_EV_GOOD 1
`define RLFS_EV_UNSENT 2
`define RLFS_EV_BAD 3
`define RLFS_EV_NOBUF 4
`define RLFS_EV_DUP 5
`define RLFS_EV_LOST 6
`define RLFS_EV_FWD 7
`define RLFS_NUM_CNT 7
`define RLFS_NUM_EV 8

// ****************************************
// sizes
// ****************************************
`define RLFS_HIST_DEPTH 20
`define RLFS_MAP_WORDS 16
`define RLFS_BCAST_ADDR 8'hff
`define RLFS_CNT_RESET 16'h0000

`endif

//--- design/rlfs_top.v
// radio link status counters, handshake mirror and store-and-forward decision
// assumes a classic wishbone master and link logic on the same clock

`timescale 1ns/100ps
`default_nettype none
`include "rlfs_consts.vh"

module rlfs_top (
   // clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [8:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // link events, one-cycle pulses except modem_lost_i
   input wire tx_sent_i,
   input wire rx_good_i,
   input wire rx_no_buf_i,
   input wire tx_blocked_i,
   input wire rx_bad_i,
   input wire modem_lost_i,
   // received packet for forwarding decision
   input wire pkt_valid_i,
   input wire [7:0] source_address_byte_i,
   input wire [7:0] pkt_dst_i,
   input wire [15:0] pkt_sig_i,
   output reg pkt_fwd_o,
   output reg pkt_dup_o,
   // modem pins
   input wire cts_i,
   input wire dsr_i,
   input wire dcd_i,
   output reg dtr_o,
   output reg rts_o,
   // interrupt
   output reg irq_o
);

   // ****************************************
   // bus decode
   // ****************************************
   wire req;
   wire [6:0] idx;
   wire wr_lo;
   wire wr_hi;
   wire wr_b2;
   assign req = wb_cyc_i & wb_stb_i;
   assign idx = wb_adr_i[8:2];
   assign wr_lo = req & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign wr_hi = req & wb_we_i & wb_ack_o & wb_sel_i[1];
   assign wr_b2 = req & wb_we_i & wb_ack_o & wb_sel_i[2];

   // ****************************************
   // control register
   // ****************************************
   reg [10:0] ctrl_reg;
   wire [7:0] station;
   wire sf_en;
   wire clear_cnt;
   assign station = ctrl_reg[`RLFS_CTRL_STATION_LSB +: 8];
   assign sf_en = ctrl_reg[`RLFS_CTRL_SF_EN];
   assign clear_cnt = wr_b2 & (idx == `RLFS_IDX_CTRL) & wb_dat_i[`RLFS_CTRL_CLEAR];

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_reg <= `RLFS_CTRL_RESET;
      end else begin
         if (wr_lo && idx == `RLFS_IDX_CTRL) begin
            ctrl_reg[7:0] <= wb_dat_i[7:0];
         end
         if (wr_hi && idx == `RLFS_IDX_CTRL) begin
            ctrl_reg[10:8] <= wb_dat_i[10:8];
         end
      end
   end

   // ****************************************
   // modem control pins
   // ****************************************
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dtr_o <= 1'b0;
         rts_o <= 1'b0;
      end else begin
         dtr_o <= ctrl_reg[`RLFS_CTRL_DTR];
         rts_o <= ctrl_reg[`RLFS_CTRL_RTS];
      end
   end

   // ****************************************
   // modem input synchronisers
   // ****************************************
   reg [2:0] s1_reg;
   reg [2:0] s2_reg;
   reg [2:0] s3_reg;
   reg [2:0] lines_reg;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_reg <= 3'h0;
         s2_reg <= 3'h0;
         s3_reg <= 3'h0;
      end else begin
         s1_reg <= {dcd_i, dsr_i, cts_i};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // ****************************************
   // line level filter
   // ****************************************
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lines_reg <= 3'h0;
      end else begin
         lines_reg <= (s2_reg & s3_reg) | (lines_reg & (s2_reg | s3_reg));
      end
   end

   wire [15:0] line_word;
   assign line_word[15:5] = 11'h000;
   assign line_word[`RLFS_LINE_CTS] = lines_reg[0];
   assign line_word[`RLFS_LINE_DSR] = lines_reg[1];
   assign line_word[`RLFS_LINE_DCD] = lines_reg[2];
   assign line_word[`RLFS_LINE_DTR] = dtr_o;
   assign line_word[`RLFS_LINE_RTS] = rts_o;

   // ****************************************
   // forwarding table
   // ****************************************
   reg [255:0] map_reg;
   genvar gw;
   generate
      for (gw = 0; gw < `RLFS_MAP_WORDS; gw = gw + 1) begin : g_map
         always @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               map_reg[gw*16 +: 16] <= 16'h0000;
            end else if (idx == `RLFS_IDX_MAP_FIRST + gw) begin
               if (wr_lo) begin
                  map_reg[gw*16 +: 8] <= wb_dat_i[7:0];
               end
               if (wr_hi) begin
                  map_reg[gw*16+8 +: 8] <= wb_dat_i[15:8];
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // duplicate history
   // ****************************************
   reg [23:0] hist_reg [0:`RLFS_HIST_DEPTH-1];
   reg [`RLFS_HIST_DEPTH-1:0] hist_vld_reg;
   wire [23:0] pkt_key;
   wire [`RLFS_HIST_DEPTH-1:0] hit;
   wire push;
   assign pkt_key = {source_address_byte_i, pkt_sig_i};
   assign push = pkt_valid_i & sf_en;
   genvar gh;
   generate
      for (gh = 0; gh < `RLFS_HIST_DEPTH; gh = gh + 1) begin : g_hist
         assign hit[gh] = hist_vld_reg[gh] & (hist_reg[gh] == pkt_key);
         always @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               hist_reg[gh] <= 24'h000000;
               hist_vld_reg[gh] <= 1'b0;
            end else if (push) begin
               if (gh == 0) begin
                  hist_reg[gh] <= pkt_key;
                  hist_vld_reg[gh] <= 1'b1;
               end else begin
                  hist_reg[gh] <= hist_reg[gh-1];
                  hist_vld_reg[gh] <= hist_vld_reg[gh-1];
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // forward decision
   // ****************************************
   wire is_dup;
   wire own_src;
   wire is_bcast;
   wire src_ok;
   wire dst_ok;
   wire dst_other;
   wire do_fwd;
   assign is_dup = push & (|hit);
   assign own_src = (source_address_byte_i == station);
   assign is_bcast = (pkt_dst_i == `RLFS_BCAST_ADDR);
   assign src_ok = map_reg[source_address_byte_i];
   assign dst_ok = is_bcast ? map_reg[`RLFS_BCAST_ADDR] : map_reg[pkt_dst_i];
   assign dst_other = (pkt_dst_i != station);
   assign do_fwd = push & ~is_dup & ~own_src & dst_other & src_ok & dst_ok;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pkt_fwd_o <= 1'b0;
         pkt_dup_o <= 1'b0;
      end else begin
         pkt_fwd_o <= do_fwd;
         pkt_dup_o <= is_dup;
      end
   end

   // ****************************************
   // diagnostic counters
   // ****************************************
   reg lost_d_reg;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lost_d_reg <= 1'b0;
      end else begin
         lost_d_reg <= modem_lost_i;
      end
   end

   wire [`RLFS_NUM_EV-1:0] ev;
   assign ev[`RLFS_EV_SENT] = tx_sent_i;
   assign ev[`RLFS_EV_GOOD] = rx_good_i;
   assign ev[`RLFS_EV_UNSENT] = tx_blocked_i;
   assign ev[`RLFS_EV_BAD] = rx_bad_i;
   assign ev[`RLFS_EV_NOBUF] = rx_no_buf_i;
   assign ev[`RLFS_EV_DUP] = is_dup;
   assign ev[`RLFS_EV_LOST] = modem_lost_i & ~lost_d_reg;
   assign ev[`RLFS_EV_FWD] = do_fwd;

   reg [15:0] cnt_reg [0:`RLFS_NUM_CNT-1];
   genvar gc;
   generate
      for (gc = 0; gc < `RLFS_NUM_CNT; gc = gc + 1) begin : g_cnt
         always @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               cnt_reg[gc] <= `RLFS_CNT_RESET;
            end else if (clear_cnt) begin
               cnt_reg[gc] <= `RLFS_CNT_RESET;
            end else if (ev[gc]) begin
               cnt_reg[gc] <= cnt_reg[gc] + 16'h0001;
            end
         end
      end
   endgenerate

   // ****************************************
   // interrupt status and mask
   // ****************************************
   reg [`RLFS_NUM_EV-1:0] irq_stat_reg;
   reg [`RLFS_NUM_EV-1:0] irq_mask_reg;
   wire [`RLFS_NUM_EV-1:0] w1c;
   assign w1c = (wr_lo && idx == `RLFS_IDX_IRQ_STAT) ? wb_dat_i[7:0] : 8'h00;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_stat_reg <= 8'h00;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~w1c) | ev;
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_mask_reg <= 8'h00;
      end else if (wr_lo && idx == `RLFS_IDX_IRQ_MASK) begin
         irq_mask_reg <= wb_dat_i[7:0];
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // ****************************************
   // read mux and ack
   // ****************************************
   reg [31:0] rd_data;
   always @* begin
      rd_data = 32'h00000000;
      case (idx)
         `RLFS_IDX_LINES: begin
            rd_data[15:0] = line_word;
         end
         `RLFS_IDX_SENT: begin
            rd_data[15:0] = cnt_reg[`RLFS_EV_SENT];
         end
         `RLFS_IDX_GOOD: begin
            rd_data[15:0] = cnt_reg[`RLFS_EV_GOOD];
         end
         `RLFS_IDX_UNSENT: begin
            rd_data[15:0] = cnt_reg[`RLFS_EV_UNSENT];
         end
         `RLFS_IDX_BAD: begin
            rd_data[15:0] = cnt_reg[`RLFS_EV_BAD];
         end
         `RLFS_IDX_NOBUF: begin
            rd_data[15:0] = cnt_reg[`RLFS_EV_NOBUF];
         end
         `RLFS_IDX_DUP: begin
            rd_data[15:0] = cnt_reg[`RLFS_EV_DUP];
         end
         `RLFS_IDX_LOST: begin
            rd_data[15:0] = cnt_reg[`RLFS_EV_LOST];
         end
         `RLFS_IDX_CTRL: begin
            rd_data[10:0] = ctrl_reg;
         end
         `RLFS_IDX_IRQ_STAT: begin
            rd_data[7:0] = irq_stat_reg;
         end
         `RLFS_IDX_IRQ_MASK: begin
            rd_data[7:0] = irq_mask_reg;
         end
         default: begin
            // table word k sits at index first + k, so subtract the first index
            if (idx >= `RLFS_IDX_MAP_FIRST && idx <= `RLFS_IDX_MAP_LAST) begin
               rd_data[15:0] = map_reg[{idx[3:0] - 4'h3, 4'h0} +: 16];
            end
         end
      endcase
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wb_dat_o <= 32'h00000000;
      end else if (req && !wb_ack_o) begin
         wb_dat_o <= rd_data;
      end
   end

endmodule
`default_nettype wire

//--- sim/rlfs_sva.sv
// checker: bus, packet and pin relations at the rlfs_top ports
// assumes one clock and an active-low reset
`timescale 1ns/100ps
`default_nettype none
module rlfs_sva (
   // clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // bus
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [8:0] wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   // packet and pins
   input wire pkt_valid_i,
   input wire pkt_fwd_o,
   input wire pkt_dup_o,
   input wire dtr_o,
   input wire rts_o,
   input wire irq_o
);
   // ****
   // properties
   // ****
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
   rd_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000) else $error("upper bits set");
   line_mirror_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[8:2] == 7'h00
      |-> wb_dat_o[4] == dtr_o && wb_dat_o[1] == rts_o) else $error("pin mirror wrong");
   pins_write_a: assert property (!$stable(dtr_o) || !$stable(rts_o)
      |-> $past(wb_ack_o && wb_we_i, 2)) else $error("pin moved without write");
   pkt_quiet_a: assert property (!pkt_valid_i |=> !pkt_fwd_o && !pkt_dup_o) else $error("decision unasked");
   fwd_dup_a: assert property (pkt_dup_o |-> !pkt_fwd_o) else $error("duplicate repeated");
   fwd_c: cover property (pkt_fwd_o);
   dup_c: cover property (pkt_dup_o);
   irq_c: cover property (irq_o);
endmodule
bind rlfs_top rlfs_sva i_rlfs_sva (.clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_dat_o, .wb_ack_o, .pkt_valid_i, .pkt_fwd_o, .pkt_dup_o, .dtr_o, .rts_o, .irq_o);
`default_nettype wire

//--- sim/rlfs_modem.sv
// modem model: answers rts with cts and dtr with dsr after a delay
// assumes the block's clock; carrier level comes from the bench
`timescale 1ns/100ps
`default_nettype none
module rlfs_modem #(parameter int DLY = 4) (
   // clock
   input wire logic clk_i,
   // lines from the block, and carrier level from the bench
   input wire logic rts_i,
   input wire logic dtr_i,
   input wire logic carrier_i,
   // lines to the block
   output logic cts_o,
   output logic dsr_o,
   output logic dcd_o
);
   // ****
   // delayed answers
   // ****
   logic [DLY-1:0] rts_q = '0, dtr_q = '0;
   always @(posedge clk_i) begin
      rts_q <= {rts_q[DLY-2:0], rts_i};
      dtr_q <= {dtr_q[DLY-2:0], dtr_i};
   end
   assign cts_o = rts_q[DLY-1];
   assign dsr_o = dtr_q[DLY-1];
   assign dcd_o = carrier_i;
endmodule
`default_nettype wire

//--- sim/test_rlfs_top.sv
// testbench for rlfs_top: registers, events, irq, modem lines, forwarding
// assumes rlfs_modem on the modem pins and the constants header on the path
`timescale 1ns/100ps
`default_nettype none
`include "rlfs_consts.vh"
module test_rlfs_top;
   logic clk_i = 1'b0, rst_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic pkt_valid_i = 1'b0, modem_lost_i = 1'b0, carrier = 1'b0;
   logic wb_ack_o, pkt_fwd_o, pkt_dup_o, dtr_o, rts_o, irq_o, cts_i, dsr_i, dcd_i;
   logic [8:0] wb_adr_i = 9'h000;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [4:0] ev = 5'h00;
   logic [7:0] source_address_byte_i = 8'h00, pkt_dst_i = 8'h00;
   logic [15:0] pkt_sig_i = 16'h0000;
   logic [6:0] cnt_idx [7] = '{`RLFS_IDX_SENT, `RLFS_IDX_GOOD, `RLFS_IDX_UNSENT, `RLFS_IDX_BAD,
      `RLFS_IDX_NOBUF, `RLFS_IDX_DUP, `RLFS_IDX_LOST};
   int fail_count = 0, checked = 0, cycles = 0;
   always #5 clk_i = ~clk_i;
   rlfs_top i_rlfs_top (.clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf),
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_sent_i(ev[0]), .rx_good_i(ev[1]), .tx_blocked_i(ev[2]),
      .rx_bad_i(ev[3]), .rx_no_buf_i(ev[4]), .modem_lost_i, .pkt_valid_i, .source_address_byte_i,
      .pkt_dst_i, .pkt_sig_i, .pkt_fwd_o, .pkt_dup_o, .cts_i, .dsr_i, .dcd_i, .dtr_o, .rts_o, .irq_o);
   rlfs_modem i_rlfs_modem (.clk_i, .rts_i(rts_o), .dtr_i(dtr_o), .carrier_i(carrier),
      .cts_o(cts_i), .dsr_o(dsr_i), .dcd_o(dcd_i));
   // ****
   // tasks
   // ****
   task complete_run();
      if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   task chk_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wb(input logic we, input logic [6:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, idx, 2'b00, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1) fail_count++;
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   task rdchk(input logic [6:0] idx, input logic [31:0] exp);
      wb(1'b0, idx, 32'h0);
      chk_word(rd, exp);
   endtask
   task pulse(input int k);
      @(posedge clk_i) ev[k] <= 1'b1;
      @(posedge clk_i) ev[k] <= 1'b0;
   endtask
   task pkt(input logic [7:0] s, input logic [7:0] d, input logic [15:0] g, input logic [1:0] exp);
      @(posedge clk_i);
      {pkt_valid_i, source_address_byte_i, pkt_dst_i, pkt_sig_i} <= {1'b1, s, d, g};
      @(posedge clk_i);
      {pkt_valid_i, source_address_byte_i, pkt_dst_i, pkt_sig_i} <= {1'b0, ~{s, d, g}};
      #1 chk_word({30'h0, pkt_fwd_o, pkt_dup_o}, {30'h0, exp});
   endtask
   task t_regs();
      foreach (cnt_idx[i]) rdchk(cnt_idx[i], 32'h0);
      wb(1'b1, `RLFS_IDX_SENT, 32'h1234);
      rdchk(`RLFS_IDX_SENT, 32'h0);
      rdchk(7'h10, 32'h0);
      wb(1'b1, `RLFS_IDX_MAP_LAST, 32'hffff_a5c3);
      rdchk(`RLFS_IDX_MAP_LAST, 32'h0000_a5c3);
      wb(1'b1, `RLFS_IDX_MAP_LAST, 32'h0);
   endtask
   task t_events();
      for (int k = 0; k < 5; k++) repeat (k + 1) pulse(k);
      repeat (2) begin
         @(posedge clk_i) modem_lost_i <= 1'b1;
         repeat (3) @(posedge clk_i);
         modem_lost_i <= 1'b0;
      end
      for (int k = 0; k < 5; k++) rdchk(cnt_idx[k], 32'(k + 1));
      rdchk(`RLFS_IDX_LOST, 32'h2);
      rdchk(`RLFS_IDX_IRQ_STAT, 32'h5f);
      chk_word({31'h0, irq_o}, 32'h0);
      wb(1'b1, `RLFS_IDX_IRQ_MASK, 32'h40);
      @(posedge clk_i);
      #1 chk_word({31'h0, irq_o}, 32'h1);
      wb(1'b1, `RLFS_IDX_IRQ_STAT, 32'h40);
      @(posedge clk_i);
      #1 chk_word({31'h0, irq_o}, 32'h0);
      rdchk(`RLFS_IDX_IRQ_STAT, 32'h1f);
      wb(1'b1, `RLFS_IDX_CTRL, 32'h1_0000);
      foreach (cnt_idx[i]) rdchk(cnt_idx[i], 32'h0);
   endtask
   task t_lines();
      carrier <= 1'b1;
      wb(1'b1, `RLFS_IDX_CTRL, 32'h200);
      repeat (20) @(posedge clk_i);
      rdchk(`RLFS_IDX_LINES, 32'h1c);
      carrier <= 1'b0;
      wb(1'b1, `RLFS_IDX_CTRL, 32'h400);
      repeat (20) @(posedge clk_i);
      rdchk(`RLFS_IDX_LINES, 32'h03);
   endtask
   task t_fwd();
      pkt(8'h01, 8'h03, 16'h0100, 2'b00);
      wb(1'b1, `RLFS_IDX_CTRL, 32'h102);
      pkt(8'h01, 8'h03, 16'h0100, 2'b00);
      pkt(8'h01, 8'h03, 16'h0100, 2'b01);
      wb(1'b1, `RLFS_IDX_MAP_FIRST, 32'h000e);
      pkt(8'h01, 8'h03, 16'h0101, 2'b10);
      pkt(8'h01, 8'h04, 16'h0102, 2'b00);
      pkt(8'h02, 8'h03, 16'h0103, 2'b00);
      pkt(8'h01, 8'hff, 16'h0104, 2'b00);
      wb(1'b1, `RLFS_IDX_MAP_LAST, 32'h8000);
      pkt(8'h03, 8'hff, 16'h0105, 2'b10);
      for (int i = 0; i < 20; i++) pkt(8'h01, 8'h03, 16'h0200 + 16'(i), 2'b10);
      pkt(8'h01, 8'h03, 16'h0200, 2'b01);
      pkt(8'h01, 8'h03, 16'h0101, 2'b10);
      rdchk(`RLFS_IDX_DUP, 32'h2);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_events();
      t_lines();
      t_fwd();
      complete_run();
   end
endmodule
`default_nettype wire
